// ### wid_dispatch.sv
// top of the wake-up and interrupt dispatch block
//
// Functional notes
// [RULE1] comparator change with both enables clear neither wakes nor interrupts
// [RULE2] comparator wake enable alone wakes and resumes, never interrupts
// [RULE3] comparator irq enable alone: no wake; vector or continue by global state
// [RULE4] both comparator enables: wake, then vector or continue by global state
// [RULE5] timer one irq enable wakes from idle only, vector by global state
// [RULE6] timer one irq enable clear: no wake, no interrupt
// [RULE7] uart transmit done never wakes; interrupts when enabled
// [RULE8] uart receive full never wakes; interrupts when enabled
// [RULE9] uart receive error never wakes; interrupts when enabled
// [RULE10] uart source with enable clear is silent in every mode
// [RULE11] timer two irq enable wakes from idle only, vector by global state
// [RULE12] timer three irq enable wakes from idle only, vector by global state
// [RULE13] pwm period match wakes from idle only, vector by global state
// [RULE14] global enabled after wake: service interrupt, then next instruction
// [RULE15] global disabled after wake: resume at next instruction
// [RULE16] software uses serial wake only with the interface as slave
// [RULE17] software disables watchdog before comparator-only sleep wake
// [RULE18] serial slave with wake enable wakes once a transfer is received
// [RULE19] enable and disable instructions set and clear the global state
`timescale 1ns/100ps
module wid_dispatch
  import wid_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic [1:0] POWER_MODE,
  input wire logic CMP2_OUT,
  input wire logic TIMER_ONE_EVENT,
  input wire logic TIMER_TWO_EVENT,
  input wire logic TIMER_THREE_EVENT,
  input wire logic UART_TX_DONE,
  input wire logic UART_RX_FULL,
  input wire logic UART_RX_ERROR,
  input wire logic PWM_A_MATCH,
  input wire logic PWM_B_MATCH,
  input wire logic SPI_RX_DONE,
  input wire logic SPI_SLAVE_MODE,
  input wire logic GLOBAL_IRQ_ENABLE_INSTR,
  input wire logic GLOBAL_IRQ_DISABLE_INSTR,
  input wire logic ISR_RETURN,
  output logic WAKE,
  output logic RESUME_NEXT,
  output logic VECTOR,
  output logic IRQ,
  output logic GLOBAL_IRQ_STATE
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    wid_state_t state;
    logic [1:0] ctrl;
    logic [9:0] irq_enable;
    logic gie;
    logic [15:0] rdata;
    logic wake;
    logic resume;
    logic vector;
  } wid_top_state_t;

  wid_top_state_t cur;
  wid_top_state_t nxt;

  logic cmp2_change;
  logic [9:0] events;
  logic [9:0] wake_en;
  logic [9:0] clear;
  logic [9:0] status;
  logic [9:0] wake_req;
  logic [9:0] irq_req;
  logic any_wake;
  logic any_irq;
  logic active_mode;
  logic low_power;
  logic gie_after_instr;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_clear;
  logic servicing;
  logic [15:0] ctrl_word;
  logic [15:0] enable_word;
  logic [15:0] status_word;
  logic [15:0] state_word;

  // ********************************************************************
  // comparator change detection
  // ********************************************************************
  wid_change_detect u_cmp2_change (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .level(CMP2_OUT),
    .change(cmp2_change)
  );

  // event vector in source bit order
  always_comb begin
    events = '0;
    events[WID_SRC_CMP2] = cmp2_change;
    events[WID_SRC_TIMER1] = TIMER_ONE_EVENT;
    events[WID_SRC_UART_TX] = UART_TX_DONE;
    events[WID_SRC_UART_RXF] = UART_RX_FULL;
    events[WID_SRC_UART_ERR] = UART_RX_ERROR;
    events[WID_SRC_TIMER2] = TIMER_TWO_EVENT;
    events[WID_SRC_TIMER3] = TIMER_THREE_EVENT;
    events[WID_SRC_PWM_A] = PWM_A_MATCH;
    events[WID_SRC_PWM_B] = PWM_B_MATCH;
    events[WID_SRC_SPI] = SPI_RX_DONE;
  end

  // wake enables exist only for the comparator and the serial slave
  always_comb begin
    wake_en = '0;
    wake_en[WID_SRC_CMP2] = cur.ctrl[WID_CTRL_CMP2_WAKE];
    wake_en[WID_SRC_SPI] = cur.ctrl[WID_CTRL_SPI_WAKE] && SPI_SLAVE_MODE; // [RULE16] [RULE18]
  end

  // ********************************************************************
  // register decode
  // ********************************************************************
  // one write strobe per writable register
  always_comb begin
    wr_ctrl = REG_WR && (REG_ADDR == WID_REG_CTRL);
    wr_enable = REG_WR && (REG_ADDR == WID_REG_IRQ_ENABLE);
    wr_clear = REG_WR && (REG_ADDR == WID_REG_CLEAR);
  end

  // write to the clear register drops the selected status bits
  assign clear = wr_clear ? REG_WDATA[9:0] : 10'h000;

  // ********************************************************************
  // read images
  // ********************************************************************
  // fields at their package positions, unused bits read as zero
  always_comb begin
    servicing = (cur.state == WID_ST_SERVICE);
    ctrl_word = 16'h0000;
    ctrl_word[WID_CTRL_CMP2_WAKE] = cur.ctrl[WID_CTRL_CMP2_WAKE];
    ctrl_word[WID_CTRL_SPI_WAKE] = cur.ctrl[WID_CTRL_SPI_WAKE];
    enable_word = 16'h0000;
    enable_word[9:0] = cur.irq_enable;
    status_word = 16'h0000;
    status_word[9:0] = status;
    state_word = 16'h0000;
    state_word[WID_STATE_GIE] = cur.gie;
    state_word[WID_STATE_MODE_LO +: 2] = POWER_MODE;
    state_word[WID_STATE_SERVICE] = servicing;
  end

  // ********************************************************************
  // event sources
  // ********************************************************************
  function automatic wid_wake_class_t wid_class_of(input int idx);
    if (idx == WID_SRC_CMP2 || idx == WID_SRC_SPI) begin
      return WID_WAKE_BY_WE;
    end else if (idx == WID_SRC_UART_TX || idx == WID_SRC_UART_RXF ||
                 idx == WID_SRC_UART_ERR) begin
      return WID_WAKE_NEVER;
    end else begin
      return WID_WAKE_IDLE_BY_IE;
    end
  endfunction : wid_class_of

  // one source instance per bit
  for (genvar g = 0; g < WID_NUM_SRC; g++) begin : g_src
    wid_source #(
      .WAKE_CLASS(wid_class_of(g))
    ) u_src (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .event_pulse(events[g]),
      .irq_enable(cur.irq_enable[g]),
      .wake_enable(wake_en[g]),
      .clear(clear[g]),
      .power_mode(POWER_MODE),
      .status(status[g]),
      .wake_req(wake_req[g]),
      .irq_req(irq_req[g])
    );
  end

  // ********************************************************************
  // dispatch decision
  // ********************************************************************
  always_comb begin
    any_wake = |wake_req;
    any_irq = |irq_req;
    low_power = (POWER_MODE == WID_MODE_SLEEP) || (POWER_MODE == WID_MODE_IDLE);
    active_mode = (POWER_MODE == WID_MODE_GREEN) || (POWER_MODE == WID_MODE_NORMAL);
  end

  // ********************************************************************
  // global interrupt state
  // ********************************************************************
  // core instructions; enable wins when both come in one cycle
  always_comb begin
    gie_after_instr = cur.gie;
    if (GLOBAL_IRQ_DISABLE_INSTR) begin
      gie_after_instr = 1'b0; // [RULE19]
    end
    if (GLOBAL_IRQ_ENABLE_INSTR) begin
      gie_after_instr = 1'b1; // [RULE19]
    end
  end

  // ********************************************************************
  // sequencer
  // ********************************************************************
  // sequencing, global state and register file
  always_comb begin
    nxt = cur;
    nxt.wake = 1'b0;
    nxt.resume = 1'b0;
    nxt.vector = 1'b0;
    nxt.rdata = 16'h0000;

    // global interrupt state from the core's instructions
    nxt.gie = gie_after_instr; // [RULE19]

    case (cur.state)
      WID_ST_RUN: begin
        if (low_power && any_wake) begin
          // wake-up, then branch on the global state
          nxt.wake = 1'b1;
          if (cur.gie && any_irq) begin
            nxt.vector = 1'b1; // [RULE3] [RULE4] [RULE14] [RULE19]
            nxt.gie = 1'b0;
            nxt.state = WID_ST_SERVICE;
          end else begin
            nxt.resume = 1'b1; // [RULE2] [RULE15]
          end
        end else if (active_mode && cur.gie && any_irq) begin
          // running: vector only while globally enabled
          nxt.vector = 1'b1; // [RULE3] [RULE5] [RULE7] [RULE8] [RULE9] [RULE13] [RULE19]
          nxt.gie = 1'b0;
          nxt.state = WID_ST_SERVICE;
        end
      end
      WID_ST_SERVICE: begin
        // handler done: re-enable and carry on with the next instruction
        if (ISR_RETURN) begin
          nxt.gie = 1'b1;
          nxt.resume = 1'b1; // [RULE14]
          nxt.state = WID_ST_RUN;
        end
      end
      default: begin
        nxt.state = WID_ST_RUN;
      end
    endcase

    // register writes; status, state and unmapped offsets ignore writes
    if (wr_ctrl) begin
      nxt.ctrl = REG_WDATA[1:0];
    end
    if (wr_enable) begin
      nxt.irq_enable = REG_WDATA[9:0];
    end

    // register reads, data in the following cycle
    if (REG_RD) begin
      case (REG_ADDR)
        WID_REG_CTRL: nxt.rdata = ctrl_word;
        WID_REG_IRQ_ENABLE: nxt.rdata = enable_word;
        WID_REG_STATUS: nxt.rdata = status_word;
        WID_REG_STATE: nxt.rdata = state_word;
        WID_REG_CLEAR: nxt.rdata = 16'h0000; // write only
        default: nxt.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cur.state <= WID_ST_RUN;
      cur.ctrl <= WID_CTRL_RESET;
      cur.irq_enable <= WID_IRQ_ENABLE_RESET;
      cur.gie <= WID_GIE_RESET;
      cur.rdata <= 16'h0000;
      cur.wake <= 1'b0;
      cur.resume <= 1'b0;
      cur.vector <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign REG_RDATA = cur.rdata;
  assign WAKE = cur.wake;
  assign RESUME_NEXT = cur.resume;
  assign VECTOR = cur.vector;
  assign IRQ = any_irq; // enabled sticky status pending
  assign GLOBAL_IRQ_STATE = cur.gie;

endmodule : wid_dispatch

// ### wid_pkg.sv
// constants, register map and types of the wake-up and interrupt dispatch block
package wid_pkg;

  // ********************************************************************
  // register bus geometry
  // ********************************************************************
  localparam int WID_ADDR_W = 4;
  localparam int WID_DATA_W = 16;
  localparam int WID_NUM_SRC = 10;

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [3:0] WID_REG_CTRL = 4'h0;
  localparam logic [3:0] WID_REG_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] WID_REG_STATUS = 4'h2;
  localparam logic [3:0] WID_REG_CLEAR = 4'h3;
  localparam logic [3:0] WID_REG_STATE = 4'h4;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int WID_CTRL_CMP2_WAKE = 0;
  localparam int WID_CTRL_SPI_WAKE = 1;
  localparam int WID_STATE_GIE = 0;
  localparam int WID_STATE_MODE_LO = 1;
  localparam int WID_STATE_SERVICE = 3;

  // source bit positions in enable, status and clear registers
  localparam int WID_SRC_CMP2 = 0;
  localparam int WID_SRC_TIMER1 = 1;
  localparam int WID_SRC_UART_TX = 2;
  localparam int WID_SRC_UART_RXF = 3;
  localparam int WID_SRC_UART_ERR = 4;
  localparam int WID_SRC_TIMER2 = 5;
  localparam int WID_SRC_TIMER3 = 6;
  localparam int WID_SRC_PWM_A = 7;
  localparam int WID_SRC_PWM_B = 8;
  localparam int WID_SRC_SPI = 9;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [1:0] WID_CTRL_RESET = 2'h0;
  localparam logic [9:0] WID_IRQ_ENABLE_RESET = 10'h000;
  localparam logic [9:0] WID_STATUS_RESET = 10'h000;
  localparam logic WID_GIE_RESET = 1'b0;

  // ********************************************************************
  // power modes reported by the core
  // ********************************************************************
  localparam logic [1:0] WID_MODE_SLEEP = 2'h0;
  localparam logic [1:0] WID_MODE_IDLE = 2'h1;
  localparam logic [1:0] WID_MODE_GREEN = 2'h2;
  localparam logic [1:0] WID_MODE_NORMAL = 2'h3;

  // ********************************************************************
  // wake capability of a source
  // ********************************************************************
  typedef enum logic [1:0] {
    WID_WAKE_NEVER,
    WID_WAKE_IDLE_BY_IE,
    WID_WAKE_BY_WE
  } wid_wake_class_t;

  // dispatcher sequencing states
  typedef enum logic [1:0] {
    WID_ST_RUN,
    WID_ST_SERVICE
  } wid_state_t;

endpackage : wid_pkg

// ### wid_change_detect.sv
// one-cycle pulse on every change of a level input
`timescale 1ns/100ps
module wid_change_detect
  import wid_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output logic change
);

  typedef struct packed {
    logic prev;
    logic primed;
    logic change;
  } wid_cd_state_t;

  wid_cd_state_t cur;
  wid_cd_state_t nxt;

  // compare with the previous sample; first sample after reset only primes
  always_comb begin
    nxt = cur;
    nxt.prev = level;
    nxt.primed = 1'b1;
    nxt.change = cur.primed && (level != cur.prev);
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign change = cur.change;

endmodule : wid_change_detect

// ### wid_source.sv
// one event source: sticky status, wake request and interrupt request
`timescale 1ns/100ps
module wid_source
  import wid_pkg::*;
#(
  parameter wid_wake_class_t WAKE_CLASS = WID_WAKE_NEVER
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_pulse,
  input wire logic irq_enable,
  input wire logic wake_enable,
  input wire logic clear,
  input wire logic [1:0] power_mode,
  output logic status,
  output logic wake_req,
  output logic irq_req
);

  typedef struct packed {
    logic status;
    logic wake;
  } wid_src_state_t;

  wid_src_state_t cur;
  wid_src_state_t nxt;
  logic low_power;
  logic may_wake;

  // wake permission by class and current power mode
  always_comb begin
    low_power = (power_mode == WID_MODE_SLEEP) || (power_mode == WID_MODE_IDLE);
    case (WAKE_CLASS)
      WID_WAKE_BY_WE: may_wake = wake_enable && low_power; // [RULE1] [RULE2] [RULE4] [RULE18]
      WID_WAKE_IDLE_BY_IE: may_wake = irq_enable && (power_mode == WID_MODE_IDLE); // [RULE5] [RULE6] [RULE11] [RULE12] [RULE13]
      default: may_wake = 1'b0; // [RULE7] [RULE8] [RULE9] [RULE10]
    endcase
  end

  // sticky status, set wins over clear; wake request is one cycle
  always_comb begin
    nxt = cur;
    nxt.status = event_pulse || (cur.status && !clear);
    nxt.wake = event_pulse && may_wake;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign status = cur.status;
  assign wake_req = cur.wake;
  assign irq_req = cur.status && irq_enable; // [RULE1] [RULE6] [RULE10]

endmodule : wid_source

// ### wid_dispatch_properties.sv
// checker of the dispatch block port behaviour
`timescale 1ns/100ps
module wid_dispatch_properties
  import wid_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [1:0] POWER_MODE,
  input wire logic GLOBAL_IRQ_ENABLE_INSTR,
  input wire logic GLOBAL_IRQ_DISABLE_INSTR,
  input wire logic ISR_RETURN,
  input wire logic WAKE,
  input wire logic RESUME_NEXT,
  input wire logic VECTOR,
  input wire logic IRQ,
  input wire logic GLOBAL_IRQ_STATE
);
  // ****************************************************
  // output relations
  // ****************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // wake only leaves sleep or idle
  property p_wake_mode;
    WAKE |-> $past(POWER_MODE) < WID_MODE_GREEN;
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake outside low power");
  // a wake either vectors or resumes, never both
  property p_wake_pair;
    WAKE |-> VECTOR != RESUME_NEXT;
  endproperty
  a_wake_pair: assert property (p_wake_pair) else $error("wake outcome wrong");
  // vector needs global state and clears it
  property p_vec_gie;
    VECTOR |-> $past(GLOBAL_IRQ_STATE) && !GLOBAL_IRQ_STATE;
  endproperty
  a_vec_gie: assert property (p_vec_gie) else $error("vector without global");
  // vector needs an enabled pending source
  property p_vec_irq;
    VECTOR |-> $past(IRQ);
  endproperty
  a_vec_irq: assert property (p_vec_irq) else $error("vector without request");
  // enable instruction sets the global state
  property p_eni;
    GLOBAL_IRQ_ENABLE_INSTR |=> GLOBAL_IRQ_STATE || VECTOR;
  endproperty
  a_eni: assert property (p_eni) else $error("enable not taken");
  // disable instruction clears the global state
  property p_global_irq_disable_instr;
    GLOBAL_IRQ_DISABLE_INSTR && !GLOBAL_IRQ_ENABLE_INSTR && !ISR_RETURN |=> !GLOBAL_IRQ_STATE;
  endproperty
  a_global_irq_disable_instr: assert property (p_global_irq_disable_instr) else $error("disable not taken");
  // no second vector in the two cycles after a vector
  property p_vec_once;
    VECTOR |=> !VECTOR [*2];
  endproperty
  a_vec_once: assert property (p_vec_once) else $error("vector repeated");
  // handler return resumes and restores the global state
  property p_isr;
    ISR_RETURN |=> RESUME_NEXT && GLOBAL_IRQ_STATE;
  endproperty
  a_isr: assert property (p_isr) else $error("return not resumed");
  // read data only in the cycle after a read
  property p_rdata;
    !$past(REG_RD) |-> REG_RDATA == 16'h0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : wid_dispatch_properties

bind wid_dispatch wid_dispatch_properties u_wid_dispatch_properties (
  .SYS_CLK(SYS_CLK),
  .RST_N(RST_N),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .POWER_MODE(POWER_MODE),
  .GLOBAL_IRQ_ENABLE_INSTR(GLOBAL_IRQ_ENABLE_INSTR),
  .GLOBAL_IRQ_DISABLE_INSTR(GLOBAL_IRQ_DISABLE_INSTR),
  .ISR_RETURN(ISR_RETURN),
  .WAKE(WAKE),
  .RESUME_NEXT(RESUME_NEXT),
  .VECTOR(VECTOR),
  .IRQ(IRQ),
  .GLOBAL_IRQ_STATE(GLOBAL_IRQ_STATE)
);

// ### wid_core_model.sv
// processor core model: leaves the handler some cycles after a vector
`timescale 1ns/100ps
module wid_core_model #(
  parameter int ISR_LEN = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vector,
  output logic isr_return
);
  // ****************************************************
  // handler timing
  // ****************************************************
  logic [4:0] cnt;
  // handler runs ISR_LEN cycles, then one return pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 5'h00;
      isr_return <= 1'b0;
    end else begin
      isr_return <= (cnt == 5'h01);
      if (vector) begin
        cnt <= 5'(ISR_LEN);
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule : wid_core_model

// ### tb_top.sv
// self-checking testbench of the dispatch block
`timescale 1ns/100ps
module tb_top;
  import wid_pkg::*;
  // ****************************************************
  // signals and instances
  // ****************************************************
  logic SYS_CLK, RST_N, REG_WR, REG_RD, CMP2_OUT, SPI_SLAVE_MODE, ISR_RETURN;
  logic GLOBAL_IRQ_ENABLE_INSTR, GLOBAL_IRQ_DISABLE_INSTR;
  logic WAKE, RESUME_NEXT, VECTOR, IRQ, GLOBAL_IRQ_STATE;
  logic [3:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic [1:0] POWER_MODE, m;
  logic [9:0] ev;
  logic [3:0] obs, ex;
  logic g, ie, we, sl;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  wid_dispatch u_wid_dispatch (
    .SYS_CLK(SYS_CLK),
    .RST_N(RST_N),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .POWER_MODE(POWER_MODE),
    .CMP2_OUT(CMP2_OUT),
    .SPI_SLAVE_MODE(SPI_SLAVE_MODE),
    .GLOBAL_IRQ_ENABLE_INSTR(GLOBAL_IRQ_ENABLE_INSTR),
    .GLOBAL_IRQ_DISABLE_INSTR(GLOBAL_IRQ_DISABLE_INSTR),
    .ISR_RETURN(ISR_RETURN),
    .WAKE(WAKE),
    .RESUME_NEXT(RESUME_NEXT),
    .VECTOR(VECTOR),
    .IRQ(IRQ),
    .GLOBAL_IRQ_STATE(GLOBAL_IRQ_STATE),
    .TIMER_ONE_EVENT(ev[WID_SRC_TIMER1]),
    .TIMER_TWO_EVENT(ev[WID_SRC_TIMER2]),
    .TIMER_THREE_EVENT(ev[WID_SRC_TIMER3]),
    .UART_TX_DONE(ev[WID_SRC_UART_TX]),
    .UART_RX_FULL(ev[WID_SRC_UART_RXF]),
    .UART_RX_ERROR(ev[WID_SRC_UART_ERR]),
    .PWM_A_MATCH(ev[WID_SRC_PWM_A]),
    .PWM_B_MATCH(ev[WID_SRC_PWM_B]),
    .SPI_RX_DONE(ev[WID_SRC_SPI])
  );
  wid_core_model u_wid_core_model (.clk(SYS_CLK), .rst_n(RST_N), .vector(VECTOR),
    .isr_return(ISR_RETURN));
  // clock and hang guard
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // expected {irq, wake, vector, resume} of one event
  function automatic logic [3:0] expect_out(int s, logic [1:0] md, logic gi, logic en,
    logic wen, logic slv);
    logic low, wk, vec;
    low = (md < WID_MODE_GREEN);
    case (s)
      WID_SRC_CMP2: wk = wen;
      WID_SRC_SPI: wk = wen & slv;
      WID_SRC_UART_TX, WID_SRC_UART_RXF, WID_SRC_UART_ERR: wk = 1'b0;
      default: wk = en & (md == WID_MODE_IDLE);
    endcase
    vec = gi & en & (~low | wk);
    return {en, wk & low, vec, wk & low & ~vec};
  endfunction : expect_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask : rd
  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {REG_WR, REG_RD, CMP2_OUT, SPI_SLAVE_MODE} = 4'h0;
    {GLOBAL_IRQ_ENABLE_INSTR, GLOBAL_IRQ_DISABLE_INSTR} = 2'h0;
    REG_ADDR = 4'h0;
    REG_WDATA = 16'h0000;
    POWER_MODE = WID_MODE_SLEEP;
    ev = 10'h000;
    RST_N = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
    for (int s = 0; s < WID_NUM_SRC; s++) begin
      for (int k = 0; k < 64; k++) begin
        {sl, we, ie, g, m} = 6'(k);
        wr(WID_REG_IRQ_ENABLE, 16'(ie) << s);
        wr(WID_REG_CTRL, {14'h0000, we, we});
        rd(WID_REG_IRQ_ENABLE, 16'(ie) << s);
        rd(WID_REG_CTRL, {14'h0000, we, we});
        @(posedge SYS_CLK);
        POWER_MODE <= m;
        SPI_SLAVE_MODE <= sl;
        GLOBAL_IRQ_ENABLE_INSTR <= g;
        GLOBAL_IRQ_DISABLE_INSTR <= 1'b1;
        @(posedge SYS_CLK);
        {GLOBAL_IRQ_ENABLE_INSTR, GLOBAL_IRQ_DISABLE_INSTR} <= 2'h0;
        @(posedge SYS_CLK);
        if (s == WID_SRC_CMP2) CMP2_OUT <= ~CMP2_OUT;
        else ev[s] <= 1'b1;
        @(posedge SYS_CLK);
        ev <= 10'h000;
        obs = 4'h0;
        repeat (4) begin
          #1;
          obs = obs | {IRQ, WAKE, VECTOR, RESUME_NEXT};
          @(posedge SYS_CLK);
        end
        ex = expect_out(s, m, g, ie, we, sl);
        chk(16'(obs), 16'(ex));
        rd(WID_REG_STATUS, 16'h0001 << s);
        rd(WID_REG_STATE, {12'h000, ex[1], m, g & ~ex[1]});
        wr(WID_REG_CLEAR, 16'h03FF);
        repeat (16) @(posedge SYS_CLK);
        rd(WID_REG_STATE, {12'h000, 1'b0, m, g});
        chk(16'(GLOBAL_IRQ_STATE), 16'(g));
      end
    end
    report_and_stop();
  end
endmodule : tb_top
